//--- rtl/pmr_flag_bank.sv
// sticky event flags: synchronised set, write-one clear, set wins over clear
`timescale 1ns/1ps
`default_nettype none

module pmr_flag_bank
  import pmr_pkg::*;
(
  input  wire logic  sys_clk_i, // system clock
  input  wire logic  nrst_i,    // async reset, active low
  pmr_flag_if.bank   fl         // events in, clears in, flags out
);

  // ----------------------------------------------------------------
  // per-flag synchroniser and latch
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PMR_NFLAG; g++)
    begin : gen_flag
      logic meta_ff;
      logic sync_ff;
      logic flag_ff;
      logic nxt_flag;

      always_comb
      begin
        nxt_flag = (flag_ff & ~fl.clr[g]) | sync_ff;
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          flag_ff <= PMR_FLAG_RST[g];
        end
        else
        begin
          meta_ff <= fl.raw_evt[g];
          sync_ff <= meta_ff;
          flag_ff <= nxt_flag;
        end
      end

      assign fl.flag[g] = flag_ff;
    end
  endgenerate

endmodule

`default_nettype wire

//--- rtl/pmr_flag_if.sv
// carrier between the register slice and its sticky flag bank
`timescale 1ns/1ps
`default_nettype none

interface pmr_flag_if;
  logic [7:0] raw_evt;
  logic [7:0] clr;
  logic [7:0] flag;

  modport bank (input raw_evt, input clr, output flag);
  modport ctrl (output raw_evt, output clr, input flag);
endinterface

`default_nettype wire

//--- rtl/pmr_pkg.sv
// constants and types for the power-manager status and configuration register slice
package pmr_pkg;

  // ----------------------------------------------------------------
  // register access port geometry
  // ----------------------------------------------------------------
  localparam int PMR_DW = 16;
  localparam int PMR_AW = 8;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] PMR_IDX_FLAG2  = 8'h00;
  localparam logic [7:0] PMR_IDX_MONSEL = 8'h01;
  localparam logic [7:0] PMR_IDX_SVS    = 8'h02;

  // ----------------------------------------------------------------
  // main_flag_status_two field positions (data bit = device bit - 8)
  // ----------------------------------------------------------------
  localparam int PMR_B_FB_OV   = 15;
  localparam int PMR_B_UV7     = 14;
  localparam int PMR_B_CORE_ST = 12;
  localparam int PMR_B_AUX_ST  = 10;
  localparam int PMR_B_LIN_ST  = 9;
  localparam int PMR_B_PRE_UVL = 7;
  localparam int PMR_B_PRE_UVH = 6;
  localparam int PMR_B_SUP_UVL = 5;
  localparam int PMR_B_SUP_UVH = 4;
  localparam int PMR_B_WKB_LVL = 3;
  localparam int PMR_B_WKA_LVL = 2;
  localparam int PMR_B_WKB_FLG = 1;
  localparam int PMR_B_WKA_FLG = 0;

  // ----------------------------------------------------------------
  // latched flag vector: index order and power-on values
  // ----------------------------------------------------------------
  localparam int PMR_NFLAG = 8;
  localparam int PMR_F_WKA = 0;
  localparam int PMR_F_WKB = 1;
  localparam int PMR_F_SUP_UVH = 2;
  localparam int PMR_F_SUP_UVL = 3;
  localparam int PMR_F_PRE_UVH = 4;
  localparam int PMR_F_PRE_UVL = 5;
  localparam int PMR_F_UV7 = 6;
  localparam int PMR_F_FB_OV = 7;
  localparam logic [7:0] PMR_FLAG_RST = 8'h7D;

  // ----------------------------------------------------------------
  // live input vector order
  // ----------------------------------------------------------------
  localparam int PMR_NLIVE = 5;
  localparam int PMR_L_CORE = 0;
  localparam int PMR_L_AUX = 1;
  localparam int PMR_L_LIN = 2;
  localparam int PMR_L_WKA = 3;
  localparam int PMR_L_WKB = 4;

  // ----------------------------------------------------------------
  // monitor assignment and scaling offset fields
  // ----------------------------------------------------------------
  localparam int PMR_MON_LSB = 0;
  localparam int PMR_MON_W = 3;
  localparam logic [2:0] PMR_MON_RST = 3'h0;
  localparam logic [2:0] PMR_MON_EXT = 3'h0;
  localparam logic [2:0] PMR_MON_PRE = 3'h1;
  localparam logic [2:0] PMR_MON_LIN = 3'h2;
  localparam logic [2:0] PMR_MON_RSV3 = 3'h3;
  localparam logic [2:0] PMR_MON_RSV4 = 3'h4;
  localparam logic [2:0] PMR_MON_AUX = 3'h5;
  localparam int PMR_SVS_LSB = 0;
  localparam int PMR_SVS_W = 5;
  localparam logic [4:0] PMR_SVS_RST = 5'h00;

  typedef enum logic [3:0] {
    PMR_SRC_NONE = 4'h0,
    PMR_SRC_EXT  = 4'h1,
    PMR_SRC_PRE  = 4'h2,
    PMR_SRC_LIN  = 4'h4,
    PMR_SRC_AUX  = 4'h8
  } pmr_mon_src_t;

endpackage

//--- rtl/pmr_status_config_regs.sv
// power-manager status flags, monitor assignment and buck scaling offset registers
`timescale 1ns/1ps
`default_nettype none

module pmr_status_config_regs
  import pmr_pkg::*;
(
  input  wire logic              sys_clk_i,       // system clock, 20 MHz
  input  wire logic              nrst_i,          // power-on reset, async, active low
  // register access port
  input  wire logic [PMR_AW-1:0] reg_addr_i,      // register index
  input  wire logic              reg_wr_i,        // write strobe, one cycle
  input  wire logic              reg_rd_i,        // read strobe, one cycle
  input  wire logic [PMR_DW-1:0] reg_wdata_i,     // write data, device bits 23:8
  output logic      [PMR_DW-1:0] reg_rdata_o,     // read data, device bits 23:8
  output logic                   reg_ack_o,       // access answered, one cycle
  output logic                   reg_err_o,       // unmapped index, with ack
  // analog and pin events, asynchronous
  input  wire logic              prereg_fb_ov_i,  // preregulator feedback overvoltage
  input  wire logic              supply_uv7_i,    // supply uv7 detector
  input  wire logic              prereg_uvl_i,    // preregulator undervoltage low
  input  wire logic              prereg_uvh_i,    // preregulator undervoltage high
  input  wire logic              supply_uvl_i,    // supply undervoltage low
  input  wire logic              supply_uvh_i,    // supply undervoltage high
  input  wire logic              wake_a_src_i,    // wake-up caused by wake pin a
  input  wire logic              wake_b_src_i,    // wake-up caused by wake pin b
  // live states, asynchronous
  input  wire logic              core_buck_on_i,  // core buck running
  input  wire logic              aux_buck_on_i,   // aux buck running
  input  wire logic              linear_reg_on_i, // linear regulator running
  input  wire logic              wake_pin_a_i,    // wake pin a level
  input  wire logic              wake_pin_b_i,    // wake pin b level
  // scaling offset from buck control, same clock
  input  wire logic [4:0]        svs_code_i,      // core buck scaling offset code
  // configuration and status towards the device
  output logic      [2:0]        mon_one_code_o,  // stored monitor assignment code
  output pmr_mon_src_t           mon_one_src_o,   // decoded monitored regulator
  output logic                   mon_one_rsv_o,   // reserved code stored
  output logic      [7:0]        flags_o,         // latched event flags
  output logic                   flag_any_o       // any latched flag set
);

  // ----------------------------------------------------------------
  // sticky flag bank
  // ----------------------------------------------------------------
  pmr_flag_if fl ();

  assign fl.raw_evt[PMR_F_WKA]     = wake_a_src_i;
  assign fl.raw_evt[PMR_F_WKB]     = wake_b_src_i;
  assign fl.raw_evt[PMR_F_SUP_UVH] = supply_uvh_i;
  assign fl.raw_evt[PMR_F_SUP_UVL] = supply_uvl_i;
  assign fl.raw_evt[PMR_F_PRE_UVH] = prereg_uvh_i;
  assign fl.raw_evt[PMR_F_PRE_UVL] = prereg_uvl_i;
  assign fl.raw_evt[PMR_F_UV7]     = supply_uv7_i;
  assign fl.raw_evt[PMR_F_FB_OV]   = prereg_fb_ov_i;

  pmr_flag_bank u_flags (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .fl        (fl.bank)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_flag;
  logic wr_mon;

  assign wr_flag = reg_wr_i && (reg_addr_i == PMR_IDX_FLAG2);
  assign wr_mon  = reg_wr_i && (reg_addr_i == PMR_IDX_MONSEL);
  // index 2 gets no write decode, so the offset stays read-only

  // only the clear-on-write positions reach the flag bank
  always_comb
  begin
    fl.clr = 8'h00;
    if (wr_flag)
    begin
      fl.clr[PMR_F_FB_OV]   = reg_wdata_i[PMR_B_FB_OV];
      fl.clr[PMR_F_UV7]     = reg_wdata_i[PMR_B_UV7];
      fl.clr[PMR_F_PRE_UVL] = reg_wdata_i[PMR_B_PRE_UVL];
      fl.clr[PMR_F_PRE_UVH] = reg_wdata_i[PMR_B_PRE_UVH];
      fl.clr[PMR_F_SUP_UVL] = reg_wdata_i[PMR_B_SUP_UVL];
      fl.clr[PMR_F_SUP_UVH] = reg_wdata_i[PMR_B_SUP_UVH];
      fl.clr[PMR_F_WKB]     = reg_wdata_i[PMR_B_WKB_FLG];
      fl.clr[PMR_F_WKA]     = reg_wdata_i[PMR_B_WKA_FLG];
    end
  end

  // ----------------------------------------------------------------
  // live state synchronisers
  // ----------------------------------------------------------------
  logic [PMR_NLIVE-1:0] live_raw;
  logic [PMR_NLIVE-1:0] live_meta_ff;
  logic [PMR_NLIVE-1:0] live_ff;
  logic [PMR_NLIVE-1:0] nxt_live_meta;
  logic [PMR_NLIVE-1:0] nxt_live;

  assign live_raw[PMR_L_CORE] = core_buck_on_i;
  assign live_raw[PMR_L_AUX]  = aux_buck_on_i;
  assign live_raw[PMR_L_LIN]  = linear_reg_on_i;
  assign live_raw[PMR_L_WKA]  = wake_pin_a_i;
  assign live_raw[PMR_L_WKB]  = wake_pin_b_i;

  // only the second stage feeds the read image; the first may be metastable
  always_comb
  begin
    nxt_live_meta = live_raw;
    nxt_live      = live_meta_ff;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      live_meta_ff <= '0;
      live_ff      <= '0;
    end
    else
    begin
      live_meta_ff <= nxt_live_meta;
      live_ff      <= nxt_live;
    end
  end

  // ----------------------------------------------------------------
  // monitor assignment and scaling offset
  // ----------------------------------------------------------------
  logic [2:0]   mon_ff;
  logic [2:0]   nxt_mon;
  pmr_mon_src_t src_ff;
  pmr_mon_src_t nxt_src;
  logic         rsv_ff;
  logic         nxt_rsv;
  logic [4:0]   svs_ff;
  logic [4:0]   nxt_svs;

  always_comb
  begin
    nxt_mon = mon_ff;
    if (wr_mon)
    begin
      nxt_mon = reg_wdata_i[PMR_MON_LSB +: PMR_MON_W];
    end
    nxt_rsv = 1'b0;
    case (nxt_mon)
      PMR_MON_PRE:  nxt_src = PMR_SRC_PRE;
      PMR_MON_LIN:  nxt_src = PMR_SRC_LIN;
      PMR_MON_AUX:  nxt_src = PMR_SRC_AUX;
      PMR_MON_RSV3,
      PMR_MON_RSV4:
      begin
        nxt_src = PMR_SRC_NONE;
        nxt_rsv = 1'b1;
      end
      PMR_MON_EXT:  nxt_src = PMR_SRC_EXT;
      default:      nxt_src = PMR_SRC_EXT;
    endcase
    nxt_svs = svs_code_i;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mon_ff <= PMR_MON_RST;
      src_ff <= PMR_SRC_EXT;
      rsv_ff <= 1'b0;
      svs_ff <= PMR_SVS_RST;
    end
    else
    begin
      mon_ff <= nxt_mon;
      src_ff <= nxt_src;
      rsv_ff <= nxt_rsv;
      svs_ff <= nxt_svs;
    end
  end

  // ----------------------------------------------------------------
  // read images; unlisted bits stay zero and writes never reach them
  // ----------------------------------------------------------------
  logic [PMR_DW-1:0] img_flag;
  logic [PMR_DW-1:0] img_mon;
  logic [PMR_DW-1:0] img_svs;

  always_comb
  begin
    img_flag = '0;
    img_flag[PMR_B_FB_OV]   = fl.flag[PMR_F_FB_OV];
    img_flag[PMR_B_UV7]     = fl.flag[PMR_F_UV7];
    img_flag[PMR_B_CORE_ST] = live_ff[PMR_L_CORE];
    img_flag[PMR_B_AUX_ST]  = live_ff[PMR_L_AUX];
    img_flag[PMR_B_LIN_ST]  = live_ff[PMR_L_LIN];
    img_flag[PMR_B_PRE_UVL] = fl.flag[PMR_F_PRE_UVL];
    img_flag[PMR_B_PRE_UVH] = fl.flag[PMR_F_PRE_UVH];
    img_flag[PMR_B_SUP_UVL] = fl.flag[PMR_F_SUP_UVL];
    img_flag[PMR_B_SUP_UVH] = fl.flag[PMR_F_SUP_UVH];
    img_flag[PMR_B_WKB_LVL] = live_ff[PMR_L_WKB];
    img_flag[PMR_B_WKA_LVL] = live_ff[PMR_L_WKA];
    img_flag[PMR_B_WKB_FLG] = fl.flag[PMR_F_WKB];
    img_flag[PMR_B_WKA_FLG] = fl.flag[PMR_F_WKA];
    img_mon = '0;
    img_mon[PMR_MON_LSB +: PMR_MON_W] = mon_ff;
    img_svs = '0;
    img_svs[PMR_SVS_LSB +: PMR_SVS_W] = svs_ff;
  end

  // ----------------------------------------------------------------
  // access answer
  // ----------------------------------------------------------------
  logic [PMR_DW-1:0] rdata_ff;
  logic [PMR_DW-1:0] nxt_rdata;
  logic              ack_ff;
  logic              nxt_ack;
  logic              err_ff;
  logic              nxt_err;
  logic              mapped;

  always_comb
  begin
    mapped    = 1'b1;
    nxt_rdata = '0;
    case (reg_addr_i)
      PMR_IDX_FLAG2:  nxt_rdata = img_flag;
      PMR_IDX_MONSEL: nxt_rdata = img_mon;
      PMR_IDX_SVS:    nxt_rdata = img_svs; // writes here change nothing
      default:        mapped = 1'b0;
    endcase
    if (!reg_rd_i)
    begin
      nxt_rdata = '0;
    end
    nxt_ack = reg_rd_i | reg_wr_i;
    nxt_err = (reg_rd_i | reg_wr_i) & ~mapped;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
      err_ff   <= nxt_err;
    end
  end

  // ----------------------------------------------------------------
  // flag summary
  // ----------------------------------------------------------------
  logic any_ff;
  logic nxt_any;

  always_comb
  begin
    // registered, so it trails flags_o by one cycle
    nxt_any = |fl.flag;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      any_ff <= 1'b1;
    end
    else
    begin
      any_ff <= nxt_any;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o    = rdata_ff;
  assign reg_ack_o      = ack_ff;
  assign reg_err_o      = err_ff;
  assign mon_one_code_o = mon_ff;
  assign mon_one_src_o  = src_ff;
  assign mon_one_rsv_o  = rsv_ff;
  assign flags_o        = fl.flag;
  assign flag_any_o     = any_ff;

endmodule

`default_nettype wire

//--- sim/pmr_host_model.sv
// host model issuing strobed register accesses
`timescale 1ns/1ps
`default_nettype none

module pmr_host_model
  import pmr_pkg::*;
(
  input  wire logic              sys_clk_i,   // clock
  output logic      [PMR_AW-1:0] reg_addr_o,  // index
  output logic                   reg_wr_o,    // write strobe
  output logic                   reg_rd_o,    // read strobe
  output logic      [PMR_DW-1:0] reg_wdata_o, // write data
  input  wire logic [PMR_DW-1:0] reg_rdata_i, // read data
  input  wire logic              reg_ack_i,   // answer
  input  wire logic              reg_err_i    // unmapped
);
  initial
  begin
    reg_addr_o = 8'h5A;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'hA5A5;
  end

  // one-cycle strobe, answer taken in the following cycle
  task automatic xfer(input logic w, input logic [PMR_AW-1:0] a, input logic [PMR_DW-1:0] d,
                      output logic [PMR_DW-1:0] q, output logic e, output logic ok);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(negedge sys_clk_i);
    ok = reg_ack_i;
    e = reg_err_i;
    q = reg_rdata_i;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // idle bus shows the inverse so stale values cannot pass
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

`default_nettype wire

//--- sim/pmr_regs_monitor.sv
// assertion checker for the register slice ports
`timescale 1ns/1ps
`default_nettype none

module pmr_regs_monitor
  import pmr_pkg::*;
(
  input wire logic         sys_clk_i,      // clock
  input wire logic         nrst_i,         // reset, active low
  input wire logic [7:0]   reg_addr_i,     // index
  input wire logic         reg_wr_i,       // write strobe
  input wire logic         reg_rd_i,       // read strobe
  input wire logic [15:0]  reg_wdata_i,    // write data
  input wire logic [15:0]  reg_rdata_o,    // read data
  input wire logic         reg_ack_o,      // answer
  input wire logic         reg_err_o,      // unmapped
  input wire logic         prereg_fb_ov_i, // event
  input wire logic         wake_b_src_i,   // wake b source
  input wire logic         core_buck_on_i, // core on
  input wire logic         wake_pin_a_i,   // pin a
  input wire logic         wake_pin_b_i,   // pin b
  input wire logic [4:0]   svs_code_i,     // offset code
  input wire logic [2:0]   mon_one_code_o, // monitor code
  input wire pmr_mon_src_t mon_one_src_o,  // decoded source
  input wire logic         mon_one_rsv_o,  // reserved code
  input wire logic [7:0]   flags_o         // flags
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_unmapped;
    (reg_rd_i || reg_wr_i) && reg_addr_i > 8'h02 |=> reg_ack_o && reg_err_o && reg_rdata_o == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  property p_mon_store;
    reg_wr_i && reg_addr_i == 8'h01 |=> mon_one_code_o == $past(reg_wdata_i[2:0]);
  endproperty
  a_mon_store: assert property (p_mon_store) else $error("monitor code not stored");
  property p_mon_ext;
    mon_one_code_o inside {3'h0, 3'h6, 3'h7} |-> mon_one_src_o == PMR_SRC_EXT;
  endproperty
  a_mon_ext: assert property (p_mon_ext) else $error("external code decode");
  property p_mon_rsv;
    mon_one_rsv_o == (mon_one_code_o inside {3'h3, 3'h4});
  endproperty
  a_mon_rsv: assert property (p_mon_rsv) else $error("reserved code decode");
  property p_mon_reset;
    $rose(nrst_i) |-> mon_one_code_o == 3'h0 && mon_one_src_o == PMR_SRC_EXT;
  endproperty
  a_mon_reset: assert property (p_mon_reset) else $error("monitor reset value");
  property p_fbov_set;
    prereg_fb_ov_i [*2] |=> ##1 flags_o[7];
  endproperty
  a_fbov_set: assert property (p_fbov_set) else $error("event not latched");
  property p_wka_hold;
    flags_o[0] && !(reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[0]) |=> flags_o[0];
  endproperty
  a_wka_hold: assert property (p_wka_hold) else $error("wake flag lost");
  property p_wkb_clear;
    (!wake_b_src_i) [*3] ##0 (reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[1]) |=> !flags_o[1];
  endproperty
  a_wkb_clear: assert property (p_wkb_clear) else $error("wake flag not cleared");
  property p_core_live;
    core_buck_on_i [*3] ##0 (reg_rd_i && reg_addr_i == 8'h00) |=> reg_rdata_o[12];
  endproperty
  a_core_live: assert property (p_core_live) else $error("core state not shown");
  property p_pina_live;
    (!wake_pin_a_i) [*3] ##0 (reg_rd_i && reg_addr_i == 8'h00) |=> !reg_rdata_o[2];
  endproperty
  a_pina_live: assert property (p_pina_live) else $error("pin a level wrong");
  property p_pinb_live;
    wake_pin_b_i [*3] ##0 (reg_rd_i && reg_addr_i == 8'h00) |=> reg_rdata_o[3];
  endproperty
  a_pinb_live: assert property (p_pinb_live) else $error("pin b level wrong");
  property p_svs_read;
    $stable(svs_code_i) [*2] ##0 (reg_rd_i && reg_addr_i == 8'h02)
      |=> reg_rdata_o == {11'h000, $past(svs_code_i)};
  endproperty
  a_svs_read: assert property (p_svs_read) else $error("offset read wrong");
endmodule

bind pmr_status_config_regs pmr_regs_monitor mon_u (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .prereg_fb_ov_i(prereg_fb_ov_i),
  .wake_b_src_i(wake_b_src_i), .core_buck_on_i(core_buck_on_i), .wake_pin_a_i(wake_pin_a_i),
  .wake_pin_b_i(wake_pin_b_i), .svs_code_i(svs_code_i), .mon_one_code_o(mon_one_code_o),
  .mon_one_src_o(mon_one_src_o), .mon_one_rsv_o(mon_one_rsv_o), .flags_o(flags_o));

`default_nettype wire

//--- sim/pmr_status_config_regs_test.sv
// self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, x) check_val(16'(g), 16'(x))

module pmr_status_config_regs_test
  import pmr_pkg::*;
();
  typedef struct packed { logic [2:0] code; logic [3:0] src; } pmr_row_t;

  logic         sys_clk_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic [7:0]   reg_addr_i;
  logic         reg_wr_i;
  logic         reg_rd_i;
  logic [15:0]  reg_wdata_i;
  logic [15:0]  reg_rdata_o;
  logic         reg_ack_o;
  logic         reg_err_o;
  logic [7:0]   evt = 8'h00;
  logic [4:0]   live = 5'h0F;
  logic [4:0]   static_voltage_scaling = 5'h00;
  logic [2:0]   code;
  pmr_mon_src_t src;
  logic         rsv;
  logic [7:0]   flags;
  logic         any_flag;
  logic [15:0]  q;
  logic         e;
  logic         ok;
  int           mismatches = 0;
  int           checked = 0;
  int           fbit [8] = '{0, 1, 4, 5, 6, 7, 14, 15};
  pmr_row_t     rows [8] = '{'{3'h0, 4'h1}, '{3'h1, 4'h2}, '{3'h2, 4'h4}, '{3'h3, 4'h0},
                             '{3'h4, 4'h0}, '{3'h5, 4'h8}, '{3'h6, 4'h1}, '{3'h7, 4'h1}};

  always #25 sys_clk_i = ~sys_clk_i;

  pmr_host_model host_u (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_ack_i(reg_ack_o), .reg_err_i(reg_err_o));

  pmr_status_config_regs dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
    .prereg_fb_ov_i(evt[7]), .supply_uv7_i(evt[6]), .prereg_uvl_i(evt[5]),
    .prereg_uvh_i(evt[4]), .supply_uvl_i(evt[3]), .supply_uvh_i(evt[2]),
    .wake_a_src_i(evt[0]), .wake_b_src_i(evt[1]), .core_buck_on_i(live[0]),
    .aux_buck_on_i(live[1]), .linear_reg_on_i(live[2]), .wake_pin_a_i(live[3]),
    .wake_pin_b_i(live[4]), .svs_code_i(static_voltage_scaling), .mon_one_code_o(code), .mon_one_src_o(src),
    .mon_one_rsv_o(rsv), .flags_o(flags), .flag_any_o(any_flag));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check_val(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    host_u.xfer(w, a, d, q, e, ok);
    `CHECK(ok, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    acc(1'b0, a, 16'h0000);
    `CHECK(q, x);
  endtask

  task automatic conclude();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    `CHECK(flags, PMR_FLAG_RST);
    `CHECK(src, 4'h1);
    `CHECK(any_flag, 1'b1);
    rd(8'h00, 16'h56F5);
    rd(8'h01, 16'h0000);
    rd(8'h02, 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      acc(1'b1, 8'h01, {13'h1FFF, rows[i].code});
      `CHECK(src, rows[i].src);
      `CHECK(rsv, rows[i].code inside {3'h3, 3'h4});
      rd(8'h01, {13'h0000, rows[i].code});
    end
    $display("test monitor table done");
    acc(1'b1, 8'h00, 16'hFFFF);
    rd(8'h00, 16'h1604);
    `CHECK(any_flag, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      evt[i] = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      evt[i] = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      `CHECK(flags, 8'h01 << i);
      `CHECK(any_flag, 1'b1);
      rd(8'h00, 16'h1604 | (16'h0001 << fbit[i]));
      acc(1'b1, 8'h00, 16'h0001 << fbit[i]);
      rd(8'h00, 16'h1604);
    end
    evt[6] = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    acc(1'b1, 8'h00, 16'h4000);
    rd(8'h00, 16'h5604);
    evt[6] = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    acc(1'b1, 8'h00, 16'h4000);
    rd(8'h00, 16'h1604);
    $display("test events done");
    live = 5'h10;
    repeat (3) @(negedge sys_clk_i);
    acc(1'b1, 8'h00, 16'h1E0C);
    rd(8'h00, 16'h0008);
    live = 5'h0F;
    repeat (3) @(negedge sys_clk_i);
    rd(8'h00, 16'h1604);
    $display("test live done");
    static_voltage_scaling = 5'h10;
    repeat (3) @(negedge sys_clk_i);
    acc(1'b1, 8'h02, 16'hFFFF);
    rd(8'h02, 16'h0010);
    static_voltage_scaling = 5'h01;
    repeat (3) @(negedge sys_clk_i);
    rd(8'h02, 16'h0001);
    acc(1'b0, 8'h03, 16'h0000);
    `CHECK(e, 1'b1);
    `CHECK(q, 16'h0000);
    $display("test offset and unmapped done");
    acc(1'b1, 8'h01, 16'h0005);
    nrst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    `CHECK(code, 3'h0);
    `CHECK(flags, PMR_FLAG_RST);
    rd(8'h00, 16'h56F5);
    $display("test second reset done");
    conclude();
  end
endmodule

`default_nettype wire
